// ---- logic/arb_sequencer.sv ----
// converter result sequencer and its result fifo: apb registers, scan, slots, dma pointer
// result fifo between the converter and the slot file
module arb_fifo import arb_pkg::*; #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 16
) (
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_q;
	logic [AW:0]      rp_q;
	wire              full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	wire              empty = (wp_q == rp_q);
	wire              push  = in_valid_i && !full;
	wire              pop   = out_ready_i && !empty;
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem[rp_q[AW-1:0]];
	always_ff @(posedge clock_i) begin
		if (push)
			mem[wp_q[AW-1:0]] <= in_data_i;
	end
	always_ff @(posedge clock_i) begin
		if (!rstn_i || flush_i) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////
module arb_sequencer import arb_pkg::*; #(
	parameter int SLOTS  = NUM_SLOTS,
	parameter int DMA_N  = DMA_PERIOD,
	parameter int CONV_N = CONV_CYCLES
) (
	input  wire logic              clock_i,
	input  wire logic              rstn_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              trigger_i,
	input  wire logic [RES_W-1:0]  sample_i,
	output logic      [4:0]        channel_o,
	output logic                   converting_o,
	output logic                   irq_o,
	output logic                   dma_req_o,
	output logic      [15:0]       dma_addr_o
);
	// slot pointer is four bits, dma counter six, conversion timer eight
	if (SLOTS != 16 || DMA_N < 2 || DMA_N > 64
		|| CONV_N < 1 || CONV_N > 256) begin : g_bad_cfg
		$error("unsupported sequencer parameters");
	end

	function automatic logic [4:0] next_chan(input logic [31:0] sel, input logic [4:0] cur);
		logic [4:0] c;
		logic       found;
		c     = 5'h00;
		found = 1'b0;
		for (int i = 1; i <= NUM_CH; i++) begin
			if (!found && sel[5'(cur + 5'(i))]) begin
				c     = 5'(cur + 5'(i));
				found = 1'b1;
			end
		end
		return found ? c : cur;
	endfunction

	function automatic logic [4:0] first_chan(input logic [31:0] sel);
		return next_chan(sel, 5'h1F);
	endfunction

	////////////////////////////////////////////////////////////////
	// registers
	logic [15:0]      ctl1_q;
	logic [15:0]      ctl2_q;
	logic [31:0]      scan_q;
	logic [1:0]       stat_q;
	logic [15:0]      dma_addr_q;
	logic [RES_W-1:0] slot_q [SLOTS];
	logic [31:0]      prdata_q;
	logic             pready_q;
	logic             pslverr_q;

	// writes commit on the edge where the master sees pready; reads are captured one earlier
	wire        wr_acc   = psel_i && penable_i && pwrite_i && pready_q;
	wire        rd_acc   = psel_i && penable_i && !pwrite_i && !pready_q;
	wire        is_slot  = paddr_i >= OFS_SLOT_BASE && paddr_i <= OFS_SLOT_LAST;
	wire [3:0]  slot_ix  = paddr_i[5:2];
	wire        mapped   = is_slot || paddr_i == OFS_CTRL_ONE || paddr_i == OFS_CTRL_TWO
		|| paddr_i == OFS_SCAN_LO || paddr_i == OFS_SCAN_HI
		|| paddr_i == OFS_STATUS || paddr_i == OFS_DMA_ADDR;
	wire        bad      = paddr_i[1:0] != 2'b00 || !mapped;
	wire        conv_on  = ctl1_q[B_ON];
	wire        auto_cv  = ctl1_q[B_AUTO_CONV];
	wire [4:0]  samples_per_interrupt_count     = ctl2_q[B_SAMPLES_PER_INTERRUPT_COUNT_LO +: SAMPLES_PER_INTERRUPT_COUNT_W];
	wire        scan_en  = ctl2_q[B_SCAN_EN];
	wire        dma_en   = ctl2_q[B_DMA_EN];
	wire        irq_en   = ctl2_q[B_IRQ_EN];

	////////////////////////////////////////////////////////////////
	// conversion engine
	arb_state_t  st_q;
	arb_state_t  st_d;
	logic [7:0]  tmr_q;
	logic [4:0]  cnt_q;
	logic [4:0]  ch_q;
	logic [3:0]  wptr_q;
	logic [5:0]  dcnt_q;
	logic        done_q;
	logic        conv_end;
	logic        conv_start;
	logic        fifo_ready;

	wire acq_drop = wr_acc && paddr_i == OFS_CTRL_ONE && ctl1_q[B_ACQ] && !pwdata_i[B_ACQ];
	assign conv_start = (st_q == ST_SAMPLE) && (auto_cv ? trigger_i : acq_drop);
	wire   conv_due   = (st_q == ST_CONV) && tmr_q == 8'(CONV_N - 1);
	// stall the converter while the fifo is full so no result is dropped
	assign conv_end   = conv_due && fifo_ready;
	wire   last_smp   = cnt_q == samples_per_interrupt_count;

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:   if (conv_on) st_d = ST_SAMPLE;
			ST_SAMPLE: if (conv_start) st_d = ST_CONV;
			ST_CONV:   if (conv_end) st_d = ST_SAMPLE;
			default:   st_d = ST_IDLE;
		endcase
		if (!conv_on)
			st_d = ST_IDLE;
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			st_q  <= ST_IDLE;
			tmr_q <= 8'h00;
		end else begin
			st_q  <= st_d;
			tmr_q <= (st_q == ST_CONV && !conv_end) ? 8'(tmr_q + 8'h01) : 8'h00;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i || !conv_on) begin
			cnt_q  <= 5'h00;
			wptr_q <= 4'h0;
			dcnt_q <= 6'h00;
			ch_q   <= 5'h00;
		end else if (conv_end) begin
			cnt_q  <= last_smp ? 5'h00 : 5'(cnt_q + 5'h01);
			// sequential slots, channel plays no part in the index
			wptr_q <= (dma_en || last_smp) ? 4'h0 : 4'(wptr_q + 4'h1);
			dcnt_q <= (dcnt_q == 6'(DMA_N - 1)) ? 6'h00 : 6'(dcnt_q + 6'h01);
			if (scan_en)
				ch_q <= last_smp ? first_chan(scan_q) : next_chan(scan_q, ch_q);
		end else if (st_q == ST_IDLE && scan_en) begin
			ch_q <= first_chan(scan_q);
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i)
			done_q <= 1'b0;
		else if (conv_end)
			done_q <= 1'b1;
		else if (conv_start)
			done_q <= 1'b0;
		else if (wr_acc && paddr_i == OFS_CTRL_ONE)
			done_q <= done_q & pwdata_i[B_DONE]; // software clear
	end

	////////////////////////////////////////////////////////////////
	// result fifo toward the slot file
	arb_result_t fin;
	arb_result_t fout;
	logic        fvalid;
	assign fin.data    = sample_i;
	assign fin.channel = ch_q;
	assign fin.slot    = dma_en ? 4'h0 : wptr_q;

	arb_fifo #(
		.WIDTH ($bits(arb_result_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.rstn_i      (rstn_i),
		.flush_i     (!conv_on),
		.in_valid_i  (conv_end),
		.in_ready_o  (fifo_ready),
		.in_data_i   (fin),
		.out_valid_o (fvalid),
		.out_ready_i (1'b1),
		.out_data_o  (fout)
	);

	always_ff @(posedge clock_i) begin
		if (fvalid)
			slot_q[fout.slot] <= fout.data;
	end

	////////////////////////////////////////////////////////////////
	// events: interrupt flag, dma address
	wire irq_ev  = conv_end && last_smp;
	wire dma_adv = conv_end && dma_en && dcnt_q == 6'(DMA_N - 1);
	wire st_wr   = wr_acc && paddr_i == OFS_STATUS;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			stat_q     <= 2'b00;
			dma_addr_q <= DMA_ADDR_RST;
			irq_o      <= 1'b0;
			dma_req_o  <= 1'b0;
		end else begin
			// set wins over a write-one clear in the same cycle
			stat_q[B_IRQ_FLAG] <= irq_ev || (stat_q[B_IRQ_FLAG] && !(st_wr && pwdata_i[B_IRQ_FLAG]));
			// a stalled end is flagged so software can see the slot file lagging
			stat_q[B_FIFO_OVF] <= (conv_due && !fifo_ready)
				|| (stat_q[B_FIFO_OVF] && !(st_wr && pwdata_i[B_FIFO_OVF]));
			if (wr_acc && paddr_i == OFS_DMA_ADDR)
				dma_addr_q <= pwdata_i[15:0];
			else if (dma_adv)
				dma_addr_q <= 16'(dma_addr_q + 16'h0001);
			irq_o     <= irq_en && (irq_ev || stat_q[B_IRQ_FLAG]);
			dma_req_o <= conv_end && dma_en; // result waits in slot zero
		end
	end

	////////////////////////////////////////////////////////////////
	// apb slave, one wait state
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			ctl1_q <= CTRL_RST;
			ctl2_q <= CTRL_RST;
			scan_q <= SCAN_RST;
		end else if (wr_acc && !bad) begin
			if (paddr_i == OFS_CTRL_ONE)
				ctl1_q <= pwdata_i[15:0] & ~(16'h0001 << B_DONE);
			if (paddr_i == OFS_CTRL_TWO)
				ctl2_q <= pwdata_i[15:0];
			if (paddr_i == OFS_SCAN_LO)
				scan_q[15:0] <= pwdata_i[15:0];
			if (paddr_i == OFS_SCAN_HI)
				scan_q[31:16] <= pwdata_i[15:0];
		end else if (conv_start && !auto_cv) begin
			ctl1_q[B_ACQ] <= 1'b0;
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (is_slot)
			rd_mux = 32'(slot_q[slot_ix]);
		else if (paddr_i == OFS_CTRL_ONE)
			rd_mux = {16'h0000, ctl1_q[15:1], done_q};
		else if (paddr_i == OFS_CTRL_TWO)
			rd_mux = {16'h0000, ctl2_q};
		else if (paddr_i == OFS_SCAN_LO)
			rd_mux = {16'h0000, scan_q[15:0]};
		else if (paddr_i == OFS_SCAN_HI)
			rd_mux = {16'h0000, scan_q[31:16]};
		else if (paddr_i == OFS_STATUS)
			rd_mux = {30'h0000_0000, stat_q};
		else if (paddr_i == OFS_DMA_ADDR)
			rd_mux = {16'h0000, dma_addr_q};
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel_i && penable_i && !pready_q;
			pslverr_q <= psel_i && penable_i && !pready_q && bad;
			prdata_q  <= (rd_acc && !bad) ? rd_mux : 32'h0000_0000;
		end
	end
	assign pready_o  = pready_q;
	assign pslverr_o = pslverr_q;
	assign prdata_o  = prdata_q;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			channel_o    <= 5'h00;
			converting_o <= 1'b0;
		end else begin
			channel_o    <= ch_q;
			converting_o <= st_d == ST_CONV;
		end
	end
	assign dma_addr_o = dma_addr_q;

	////////////////////////////////////////////////////////////////
	// checks
	a_done_clear_start: assert property (
		@(posedge clock_i) disable iff (!rstn_i) conv_start |=> !done_q)
		else $error("complete flag not cleared at start");
	a_done_set_end: assert property (
		@(posedge clock_i) disable iff (!rstn_i) conv_end |=> done_q)
		else $error("complete flag not set at end");
	a_done_holds: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(done_q && !conv_start && !(wr_acc && paddr_i == OFS_CTRL_ONE)) |=> done_q)
		else $error("complete flag dropped early");
	a_irq_flag_count: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(conv_end && cnt_q == samples_per_interrupt_count) |=> stat_q[B_IRQ_FLAG])
		else $error("interrupt flag missed");
	a_irq_request: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(irq_en && stat_q[B_IRQ_FLAG]) |=> irq_o)
		else $error("interrupt not requested");
	a_wptr_wrap: assert property (
		@(posedge clock_i) disable iff (!rstn_i) (conv_end && last_smp) |=> wptr_q == 4'h0)
		else $error("slot pointer did not wrap");
	a_wptr_step: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(conv_end && !last_smp && !dma_en && conv_on) |=> wptr_q == $past(wptr_q) + 4'h1)
		else $error("slot pointer did not step");
	a_dma_slot_zero: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(fvalid && $past(dma_en)) |-> fout.slot == 4'h0)
		else $error("dma mode wrote past slot zero");
	a_dma_addr_step: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(dma_adv && !(wr_acc && paddr_i == OFS_DMA_ADDR))
		|=> dma_addr_q == $past(dma_addr_q) + 16'h0001)
		else $error("dma address did not advance");
	a_off_clears: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		!conv_on |=> (cnt_q == 5'h00 && wptr_q == 4'h0))
		else $error("counters not cleared when off");
	a_scan_restart: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(conv_end && last_smp && scan_en && conv_on) |=> ch_q == first_chan($past(scan_q)))
		else $error("scan list did not restart");
endmodule

// ---- logic/arb_pkg.sv ----
// package: register map, fields, constants and carrier types for the result sequencer
// Overview of operation
// - after samples_per_interrupt_count plus one conversions the conversion interrupt flag is set and, if enabled, an interrupt is requested.
// - with channel_scan_enable set, the scan list restarts at its first entry whenever the count is reached.
// - without dma_mode_enable, the result slot pointer returns to slot zero whenever the count is reached.
// - without dma_mode_enable, sixteen result slots are filled in order, one per conversion, whatever channel was converted.
// - with dma_mode_enable, every result is written to result_slot_zero only.
// - with dma_mode_enable, the DMA address pointer advances once after every thirty-second conversion.
// - the conversion-complete flag clears when a conversion starts or when software writes zero to it, sets when a conversion ends, and otherwise holds.
package arb_pkg;
	localparam int          DATA_W          = 32;
	localparam int          RES_W           = 12;
	localparam int          NUM_SLOTS       = 16;
	localparam int          DMA_PERIOD      = 32;
	localparam int          FIFO_DEPTH      = 16;
	localparam int          NUM_CH          = 32;
	// register byte addresses
	localparam logic [11:0] OFS_CTRL_ONE    = 12'h000;
	localparam logic [11:0] OFS_CTRL_TWO    = 12'h004;
	localparam logic [11:0] OFS_SCAN_LO     = 12'h008;
	localparam logic [11:0] OFS_SCAN_HI     = 12'h00C;
	localparam logic [11:0] OFS_STATUS      = 12'h010;
	localparam logic [11:0] OFS_DMA_ADDR    = 12'h014;
	localparam logic [11:0] OFS_SLOT_BASE   = 12'h040;
	localparam logic [11:0] OFS_SLOT_LAST   = 12'h07C;
	// converter_control_one fields
	localparam int          B_DONE          = 0;
	localparam int          B_ACQ           = 1;
	localparam int          B_AUTO_CONV     = 2;
	localparam int          B_ON            = 15;
	// converter_control_two fields
	localparam int          B_SAMPLES_PER_INTERRUPT_COUNT_LO       = 2;
	localparam int          SAMPLES_PER_INTERRUPT_COUNT_W          = 5;
	localparam int          B_SCAN_EN       = 10;
	localparam int          B_DMA_EN        = 11;
	localparam int          B_IRQ_EN        = 12;
	// status fields
	localparam int          B_IRQ_FLAG      = 0;
	localparam int          B_FIFO_OVF      = 1;
	localparam logic [15:0] CTRL_RST        = 16'h0000;
	localparam logic [31:0] SCAN_RST        = 32'h0000_0001;
	localparam logic [15:0] DMA_ADDR_RST    = 16'h0000;
	// converter timing, in clock cycles
	localparam int          CONV_CYCLES     = 14;

	typedef struct packed {
		logic [RES_W-1:0] data;
		logic [4:0]       channel;
		logic [3:0]       slot;
	} arb_result_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONV   = 3'b100
	} arb_state_t;
endpackage

// ---- logic/arb_fifo.sv ----
// holds no module: the result fifo is declared beside the sequencer that uses it

// ---- tb/arb_dma_reader.sv ----
// dma-side partner model: counts transfer requests raised by the sequencer
module arb_dma_reader (
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic        dma_req_i,
	output logic      [15:0] req_count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// each request stands for slot zero being moved out before the next end
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			req_count_o <= 16'h0000;
		end else if (dma_req_i) begin
			req_count_o <= req_count_o + 16'h0001;
		end
	end
endmodule

// ---- tb/test_adc_result_buffer_sequencer.sv ----
// self-checking bench for the converter result sequencer
module test_adc_result_buffer_sequencer import arb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clock_i  = 1'b0;
	logic              rstn_i   = 1'b0;
	logic              psel     = 1'b0;
	logic              penable  = 1'b0;
	logic              pwrite   = 1'b0;
	logic [11:0]       paddr    = 12'h000;
	logic [31:0]       pwdata   = 32'h0000_0000;
	logic              trigger  = 1'b0;
	logic [RES_W-1:0]  sample   = 12'h000;
	logic [31:0]       prdata_o;
	logic              pready_o;
	logic              pslverr_o;
	logic [4:0]        channel_o;
	logic              converting_o;
	logic              irq_o;
	logic              dma_req_o;
	logic [15:0]       dma_addr_o;
	logic [15:0]       dma_cnt;
	logic [31:0]       rd;
	logic              err;
	logic [4:0]        last_ch;
	int                miscompares = 0;
	int                n_checks = 0;
	int                cycles = 0;

	always #20 clock_i = ~clock_i;

	arb_sequencer #(.DMA_N(4)) u_arb_sequencer (
		.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .trigger_i(trigger),
		.sample_i(sample), .channel_o(channel_o), .converting_o(converting_o),
		.irq_o(irq_o), .dma_req_o(dma_req_o), .dma_addr_o(dma_addr_o)
	);

	arb_dma_reader u_arb_dma_reader (
		.clock_i(clock_i), .rstn_i(rstn_i), .dma_req_i(dma_req_o), .req_count_o(dma_cnt)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// hang guard: the whole sequence needs well under 3000 cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 8000) begin
			miscompares++;
			$display("[ERR] %0t timeout", $time);
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock_i);
		penable <= 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		rd = prdata_o;
		err = pslverr_o;
		if (n >= 50) begin
			miscompares++;
			$display("[ERR] %0t no ready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
			input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd & m, e, what);
	endtask

	function automatic logic [31:0] c2(input logic [4:0] n, input logic sc, input logic dm,
			input logic ie);
		c2 = 32'h0000_0000;
		c2[B_SAMPLES_PER_INTERRUPT_COUNT_LO +: SAMPLES_PER_INTERRUPT_COUNT_W] = n;
		c2[B_SCAN_EN] = sc;
		c2[B_DMA_EN] = dm;
		c2[B_IRQ_EN] = ie;
	endfunction

	task automatic restart();
		wr(OFS_CTRL_ONE, 32'h0000_0000);
		wr(OFS_CTRL_ONE, 32'h0000_8000);
	endtask

	// waits out one conversion and the few cycles its result needs to land
	task automatic wait_conv();
		int n;
		n = 0;
		while (converting_o !== 1'b1 && n < 50) begin
			@(posedge clock_i);
			n++;
		end
		last_ch = channel_o;
		// a trigger left high would start another conversion at the end
		trigger <= 1'b0;
		while (converting_o !== 1'b0 && n < 100) begin
			@(posedge clock_i);
			n++;
		end
		if (n >= 50) chk(32'h0, 32'h1, "conversion not seen");
		repeat (4) @(posedge clock_i);
	endtask

	// manual conversion: acquire, release, wait for the result to land
	task automatic conv(input logic [11:0] s, input logic see_done);
		sample <= s;
		// with see_done both writes keep the complete flag, so only the start may clear it
		wr(OFS_CTRL_ONE, 32'h0000_8002 | 32'(see_done));
		if (see_done) rdc(OFS_CTRL_ONE, 32'h1, 32'h1, "done through sample");
		wr(OFS_CTRL_ONE, 32'h0000_8000 | 32'(see_done));
		if (see_done) rdc(OFS_CTRL_ONE, 32'h1, 32'h0, "done mid conv");
		wait_conv();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clock_i);
		rstn_i <= 1'b1;
		rdc(OFS_CTRL_ONE, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl one rst");
		rdc(OFS_CTRL_TWO, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl two rst");
		rdc(OFS_SCAN_LO, 32'hFFFF_FFFF, 32'h0000_0001, "scan lo rst");
		rdc(OFS_SCAN_HI, 32'hFFFF_FFFF, 32'h0000_0000, "scan hi rst");
		rdc(OFS_DMA_ADDR, 32'hFFFF_FFFF, 32'h0000_0000, "dma addr rst");
		rdc(12'h020, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped data");
		chk({31'h0, err}, 32'h0000_0001, "unmapped err");
		$display("test reset done");

		wr(OFS_CTRL_TWO, c2(5'h0F, 1'b0, 1'b0, 1'b1));
		wr(OFS_CTRL_ONE, 32'h0000_8000);
		for (int i = 0; i < 16; i++) begin
			conv(12'h100 + 12'(i), 1'b0);
			if (i == 14) rdc(OFS_STATUS, 32'h1, 32'h0, "flag early");
		end
		rdc(OFS_STATUS, 32'h1, 32'h1, "flag at count");
		chk({31'h0, irq_o}, 32'h0000_0001, "irq raised");
		for (int i = 0; i < 16; i++) begin
			rdc(OFS_SLOT_BASE + 12'(4 * i), 32'hFFF, 32'h100 + i, "slot fill");
		end
		wr(OFS_STATUS, 32'h0000_0001);
		repeat (2) @(posedge clock_i);
		chk({31'h0, irq_o}, 32'h0000_0000, "irq cleared");
		rdc(OFS_CTRL_ONE, 32'h1, 32'h1, "done held");
		conv(12'h5A5, 1'b1);
		rdc(OFS_SLOT_BASE, 32'hFFF, 32'h5A5, "wrap slot0");
		rdc(OFS_SLOT_BASE + 12'h004, 32'hFFF, 32'h101, "slot1 kept");
		restart();
		conv(12'h3C3, 1'b0);
		rdc(OFS_SLOT_BASE, 32'hFFF, 32'h3C3, "slot0 after off");
		$display("test slots done");

		wr(OFS_CTRL_TWO, c2(5'h01, 1'b1, 1'b0, 1'b0));
		wr(OFS_SCAN_LO, 32'h0000_0007);
		restart();
		for (int i = 0; i < 4; i++) begin
			conv(12'h300 + 12'(i), 1'b0);
			chk({27'h0, last_ch}, 32'(i % 2), "scan channel");
		end
		rdc(OFS_SLOT_BASE, 32'hFFF, 32'h302, "count wrap slot0");
		rdc(OFS_SLOT_BASE + 12'h008, 32'hFFF, 32'h102, "slot2 untouched");
		$display("test scan done");

		wr(OFS_CTRL_TWO, c2(5'h00, 1'b0, 1'b1, 1'b0));
		restart();
		wr(OFS_DMA_ADDR, 32'h0000_0010);
		for (int i = 0; i < 8; i++) begin
			conv(12'h200 + 12'(i), 1'b0);
			rdc(OFS_SLOT_BASE, 32'hFFF, 32'h200 + i, "dma slot0");
		end
		chk({16'h0, dma_addr_o}, 32'h0000_0012, "dma addr step");
		chk({16'h0, dma_cnt}, 32'h0000_0008, "dma requests");
		rdc(OFS_SLOT_BASE + 12'h004, 32'hFFF, 32'h303, "dma slot1 kept");
		$display("test dma done");

		wr(OFS_CTRL_TWO, c2(5'h00, 1'b0, 1'b0, 1'b0));
		wr(OFS_CTRL_ONE, 32'h0000_0000);
		wr(OFS_CTRL_ONE, 32'h0000_8004);
		sample <= 12'h6B6;
		trigger <= 1'b1;
		wait_conv();
		rdc(OFS_SLOT_BASE, 32'hFFF, 32'h6B6, "auto slot0");
		rdc(OFS_CTRL_ONE, 32'h1, 32'h1, "auto done");
		$display("test auto done");
		finish_test();
	end
endmodule
